// file: src/pwm_pkg.sv
package pwm_pkg;
   // ------------------------------------------------------------
   // Clock and ranges
   // ------------------------------------------------------------
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned NUM_CH = 4;
   localparam int unsigned CH_W = 3;
   localparam int unsigned DUTY_W = 14;
   localparam int unsigned FREQ_W = 16;
   localparam int unsigned PER_W = 26;
   localparam logic [DUTY_W-1:0] DUTY_FULL = 14'h2710;
   localparam logic [FREQ_W-1:0] FREQ_MIN = 16'h0001;
   localparam logic [FREQ_W-1:0] FREQ_MAX = 16'hc350;
   localparam logic [PER_W-1:0] PER_CLK = 26'h2faf080;
   localparam logic [CH_W-1:0] CH_FIRST = 3'h1;
   localparam logic [CH_W-1:0] CH_LAST = 3'h4;
   localparam int unsigned DIV_STEPS = 26;
endpackage

// file: src/pwm_channel.sv
`timescale 1ns/1ns
`default_nettype none
module pwm_channel #(
   parameter int unsigned PER_W = 26
) (
   input wire logic clk, // Clock
   input wire logic rst_n, // Async reset, active low
   input wire logic load, // New period and on time are valid
   input wire logic [PER_W-1:0] per_in, // Period in clocks
   input wire logic [PER_W-1:0] on_in, // On time in clocks
   output logic pwm_out // Modulated output, high is on
);
   logic [PER_W-1:0] cnt_r, cnt_nxt;
   logic [PER_W-1:0] per_r, per_nxt;
   logic [PER_W-1:0] on_r, on_nxt;
   logic [PER_W-1:0] pper_r, pper_nxt;
   logic [PER_W-1:0] pon_r, pon_nxt;
   logic pend_r, pend_nxt;
   logic run_r, run_nxt;
   logic out_r, out_nxt;
   logic wrap;
   logic pend_now;

   assign wrap = (cnt_r >= per_r - 1'b1);
   always_comb begin
      pper_nxt = pper_r;
      pon_nxt = pon_r;
      pend_nxt = pend_r;
      per_nxt = per_r;
      on_nxt = on_r;
      run_nxt = run_r;
      cnt_nxt = cnt_r;
      pend_now = pend_r || load;
      if (load) begin
         pper_nxt = per_in;
         pon_nxt = on_in;
         pend_nxt = 1'b1;
      end
      if (!run_r || wrap) begin
         // Settings swap only at a period boundary, no runt pulses
         cnt_nxt = '0;
         if (pend_now) begin
            // A load in the boundary cycle is taken at once, not a
            // whole period later
            per_nxt = load ? per_in : pper_r;
            on_nxt = load ? on_in : pon_r;
            run_nxt = 1'b1;
            pend_nxt = 1'b0;
         end
      end else begin
         cnt_nxt = cnt_r + 1'b1;
      end
      out_nxt = run_nxt && (cnt_nxt < on_nxt);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
         per_r <= '0;
         on_r <= '0;
         pper_r <= '0;
         pon_r <= '0;
         pend_r <= 1'b0;
         run_r <= 1'b0;
         out_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         per_r <= per_nxt;
         on_r <= on_nxt;
         pper_r <= pper_nxt;
         pon_r <= pon_nxt;
         pend_r <= pend_nxt;
         run_r <= run_nxt;
         out_r <= out_nxt;
      end
   end
   assign pwm_out = out_r;

   a_idle_off: assert property (
      @(posedge clk) disable iff (!rst_n) !run_r |-> !out_r)
      else $error("output on before settings");
   a_on_count: assert property (
      @(posedge clk) disable iff (!rst_n)
      run_r && $stable(on_r) && $past(run_r) |->
         out_r == (cnt_r < on_r)) else $error("on time mismatch");
   a_swap_edge: assert property (
      @(posedge clk) disable iff (!rst_n)
      $past(run_r) && !$stable(per_r) |-> cnt_r == '0)
      else $error("settings changed mid period");
   a_count_max: assert property (
      @(posedge clk) disable iff (!rst_n) run_r |-> cnt_r < per_r)
      else $error("counter past period");
endmodule
`default_nettype wire

// file: src/four_channel_pwm.sv
`timescale 1ns/1ns
`default_nettype none
module four_channel_pwm (
   input wire logic clk, // 50 MHz clock
   input wire logic rst_n, // Async reset, active low
   input wire logic set_valid, // Modulation set statement strobe
   input wire logic [pwm_pkg::CH_W-1:0] set_channel, // Channel 1..4
   input wire logic [pwm_pkg::DUTY_W-1:0] set_duty, // Duty, 0.01 %
   input wire logic [pwm_pkg::FREQ_W-1:0] set_freq, // Frequency, Hz
   output logic set_ready, // Idle, may take a statement
   output logic set_error, // Last statement refused
   output logic [pwm_pkg::NUM_CH-1:0] pwm_out // Bit 0 is channel 1
);
   localparam int unsigned W = pwm_pkg::PER_W;
   localparam int unsigned PW = 2 * W;

   typedef enum logic [1:0] {IDLE, DIV_PER, DIV_ON, LOAD} state_e;

   // ------------------------------------------------------------
   // Statement capture and period arithmetic
   // ------------------------------------------------------------
   // A serial divider trades latency (about 55 clocks) for area.
   state_e st_r, st_nxt;
   logic [1:0] ch_r, ch_nxt;
   logic [pwm_pkg::DUTY_W-1:0] duty_r, duty_nxt;
   logic [W-1:0] dvs_r, dvs_nxt;
   logic [PW-1:0] rem_r, rem_nxt;
   logic [W-1:0] quo_r, quo_nxt;
   logic [W-1:0] per_r, per_nxt;
   logic [4:0] step_r, step_nxt;
   logic rdy_r, rdy_nxt;
   logic err_r, err_nxt;
   logic [pwm_pkg::NUM_CH-1:0] load_r, load_nxt;
   logic [PW-1:0] trial;

   function automatic logic stmt_ok(input logic [pwm_pkg::CH_W-1:0] c,
      input logic [pwm_pkg::DUTY_W-1:0] d,
      input logic [pwm_pkg::FREQ_W-1:0] f);
      stmt_ok = c >= pwm_pkg::CH_FIRST && c <= pwm_pkg::CH_LAST &&
         d <= pwm_pkg::DUTY_FULL && f >= pwm_pkg::FREQ_MIN &&
         f <= pwm_pkg::FREQ_MAX;
   endfunction

   assign trial = {rem_r[PW-2:0], 1'b0};

   always_comb begin
      st_nxt = st_r;
      ch_nxt = ch_r;
      duty_nxt = duty_r;
      dvs_nxt = dvs_r;
      rem_nxt = rem_r;
      quo_nxt = quo_r;
      per_nxt = per_r;
      step_nxt = step_r;
      rdy_nxt = rdy_r;
      err_nxt = err_r;
      load_nxt = '0;
      case (st_r)
         IDLE: begin
            if (set_valid) begin
               if (stmt_ok(set_channel, set_duty, set_freq)) begin
                  ch_nxt = 2'(set_channel - pwm_pkg::CH_FIRST);
                  duty_nxt = set_duty;
                  // Period = clock / freq, rounded to nearest clock
                  dvs_nxt = W'(set_freq);
                  rem_nxt = PW'(pwm_pkg::PER_CLK) + PW'(set_freq >> 1);
                  quo_nxt = '0;
                  step_nxt = '0;
                  rdy_nxt = 1'b0;
                  err_nxt = 1'b0;
                  st_nxt = DIV_PER;
               end else begin
                  err_nxt = 1'b1;
               end
            end
         end
         DIV_PER, DIV_ON: begin
            // Restoring division: rem holds dividend in low half, or in both halves in DIV_ON
            if (trial[PW-1:W] >= dvs_r) begin
               rem_nxt = {trial[PW-1:W] - dvs_r, trial[W-1:0]};
               quo_nxt = {quo_r[W-2:0], 1'b1};
            end else begin
               rem_nxt = trial;
               quo_nxt = {quo_r[W-2:0], 1'b0};
            end
            rem_nxt = {rem_nxt[PW-1:W], rem_nxt[W-1:0]};
            step_nxt = step_r + 5'h01;
            if (step_r == 5'(pwm_pkg::DIV_STEPS - 1)) begin
               if (st_r == DIV_PER) begin
                  per_nxt = quo_nxt;
                  // On = period * duty / 10000, rounded
                  dvs_nxt = W'(pwm_pkg::DUTY_FULL);
                  // The product fills both halves of rem; its upper
                  // half stays below the divisor, so the quotient
                  // fits in W bits even for a 1 Hz period.
                  rem_nxt = PW'(quo_nxt) * PW'(duty_r) +
                     PW'(pwm_pkg::DUTY_FULL >> 1);
                  quo_nxt = '0;
                  step_nxt = '0;
                  st_nxt = DIV_ON;
               end else begin
                  st_nxt = LOAD;
               end
            end
         end
         LOAD: begin
            load_nxt[ch_r] = 1'b1;
            rdy_nxt = 1'b1;
            st_nxt = IDLE;
         end
         default: st_nxt = IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= IDLE;
         ch_r <= '0;
         duty_r <= '0;
         dvs_r <= '0;
         rem_r <= '0;
         quo_r <= '0;
         per_r <= '0;
         step_r <= '0;
         rdy_r <= 1'b1;
         err_r <= 1'b0;
         load_r <= '0;
      end else begin
         st_r <= st_nxt;
         ch_r <= ch_nxt;
         duty_r <= duty_nxt;
         dvs_r <= dvs_nxt;
         rem_r <= rem_nxt;
         quo_r <= quo_nxt;
         per_r <= per_nxt;
         step_r <= step_nxt;
         rdy_r <= rdy_nxt;
         err_r <= err_nxt;
         load_r <= load_nxt;
      end
   end

   assign set_ready = rdy_r;
   assign set_error = err_r;

   // ------------------------------------------------------------
   // Channels
   // ------------------------------------------------------------
   for (genvar i = 0; i < pwm_pkg::NUM_CH; i++) begin : g_ch
      pwm_channel #(.PER_W(W)) u_ch (
         .clk(clk),
         .rst_n(rst_n),
         .load(load_r[i]),
         .per_in(per_r),
         .on_in(quo_r),
         .pwm_out(pwm_out[i])
      );
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // Timing figures below follow the two 26-step divisions.

   a_busy_ignore: assert property (
      @(posedge clk) disable iff (!rst_n) st_r != IDLE |-> !set_ready)
      else $error("ready while busy");
   a_load_time: assert property (
      @(posedge clk) disable iff (!rst_n)
      st_r == IDLE && set_valid &&
         stmt_ok(set_channel, set_duty, set_freq) |->
         ##54 |load_r) else $error("load not on time");
   a_bad_flag: assert property (
      @(posedge clk) disable iff (!rst_n)
      st_r == IDLE && set_valid &&
         !stmt_ok(set_channel, set_duty, set_freq) |=> set_error)
      else $error("bad statement not flagged");
   a_one_load: assert property (
      @(posedge clk) disable iff (!rst_n) $onehot0(load_r))
      else $error("several channels loaded");
   a_err_clear: assert property (
      @(posedge clk) disable iff (!rst_n)
      st_r == IDLE && set_valid &&
         stmt_ok(set_channel, set_duty, set_freq) |=> !set_error)
      else $error("error kept after good statement");
   a_ready_back: assert property (
      @(posedge clk) disable iff (!rst_n) |load_r |-> set_ready)
      else $error("not ready at load");
   a_on_in_per: assert property (
      @(posedge clk) disable iff (!rst_n) st_r == LOAD |-> quo_r <= per_r)
      else $error("on time longer than period");
   c_take: cover property (@(posedge clk) disable iff (!rst_n)
      st_r == IDLE && set_valid);
   c_load4: cover property (@(posedge clk) disable iff (!rst_n) load_r[3]);
   c_out_on: cover property (@(posedge clk) disable iff (!rst_n)
      $rose(pwm_out[0]));
   c_refuse: cover property (@(posedge clk) disable iff (!rst_n)
      st_r == IDLE && set_valid && !stmt_ok(set_channel, set_duty, set_freq));
   c_err_gone: cover property (@(posedge clk) disable iff (!rst_n)
      $fell(set_error));
endmodule
`default_nettype wire

// file: testbench/pwm_load.sv
`timescale 1ns/1ns
`default_nettype none
// ---
// Load timing each period, rise to rise
// ---
module pwm_load (
   input wire logic clk, // Clock
   input wire logic rst_n, // Reset, active low
   input wire logic drive, // Channel output, high is on
   output int per_r, // Last full period
   output int on_r, // On time within it
   output int np_r // Rises seen
);
   int cnt_r, hi_r;
   logic last_r;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {cnt_r, hi_r, per_r, on_r, np_r} <= '0;
         last_r <= 1'b0;
      end else begin
         last_r <= drive;
         if (drive && !last_r) begin
            per_r <= cnt_r;
            on_r <= hi_r;
            np_r <= np_r + 1;
            cnt_r <= 1;
            hi_r <= 1;
         end else begin
            cnt_r <= cnt_r + 1;
            hi_r <= hi_r + int'(drive);
         end
      end
   end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic clk, rst_n, set_valid, set_ready, set_error;
   logic [pwm_pkg::CH_W-1:0] set_channel;
   logic [pwm_pkg::DUTY_W-1:0] set_duty;
   logic [pwm_pkg::FREQ_W-1:0] set_freq;
   logic [pwm_pkg::NUM_CH-1:0] pwm_out;
   int per[4], on[4], np[4], ep[4], eo[4];
   int error_cnt, compares, op, oo, bad[$];
   four_channel_pwm uut (.clk(clk), .rst_n(rst_n), .set_valid(set_valid),
      .set_channel(set_channel), .set_duty(set_duty),
      .set_freq(set_freq), .set_ready(set_ready),
      .set_error(set_error), .pwm_out(pwm_out));
   for (genvar g = 0; g < 4; g++) begin : ld
      pwm_load load_i (.clk(clk), .rst_n(rst_n), .drive(pwm_out[g]),
         .per_r(per[g]), .on_r(on[g]), .np_r(np[g]));
   end
   task automatic final_report();
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic fail(string m);
      error_cnt++;
      $display("unexpected at %0t: %s", $time, m);
      if (m == "hang") final_report();
   endtask
   task automatic chk_int(int got, int exp, string m);
      compares++;
      if (got != exp) fail(m);
   endtask
   task automatic chk_lvl(logic [3:0] got, logic [3:0] exp, string m);
      compares++;
      if (got !== exp) fail(m);
   endtask
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   // Expected timing uses round-to-nearest on both counts
   task automatic send(int ch, int d, int f);
      int i;
      @(posedge clk);
      set_valid <= 1'b1;
      set_channel <= 3'(ch);
      set_duty <= 14'(d);
      set_freq <= 16'(f);
      @(posedge clk);
      set_valid <= 1'b0;
      #1;
      for (i = 0; i < 100 && set_ready !== 1'b1; i++) tick();
      if (i == 100) fail("hang");
      if (ch >= 1 && ch <= 4 && d <= 10000 && f >= 1 && f <= 50000) begin
         ep[ch-1] = (50000000 + f / 2) / f;
         eo[ch-1] = int'((longint'(ep[ch-1]) * d + 5000) / 10000);
      end
   endtask
   // In phase: first rise closes the old period, second the new one.
   // After a reload of unknown phase only the third rise is sure to
   // close a whole new period.
   task automatic measure(int g, int op, int oo);
      int n, i, k;
      n = np[g];
      k = (op < 0) ? 3 : 2;
      for (i = 0; i < 4 * ep[g] + 200 && np[g] < n + k; i++) begin
         tick();
         if (np[g] == n + 1 && op >= 0) begin
            chk_int(per[g], op, "old period cut");
            chk_int(on[g], oo, "old on time cut");
            op = -1;
         end
      end
      if (np[g] < n + k) fail("hang");
      chk_int(per[g], ep[g], "period");
      chk_int(on[g], eo[g], "on time");
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      {error_cnt, compares} = '0;
      {rst_n, set_valid, set_channel, set_duty, set_freq} = '0;
      void'($urandom(18926));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      tick();
      chk_lvl({set_error, set_ready, 2'h0}, 4'h4, "idle");
      for (int c = 1; c <= 4; c++) begin
         chk_lvl(pwm_out & ~((4'h1 << (c - 1)) - 4'h1), 4'h0, "off");
         send(c, $urandom_range(9900, 100), $urandom_range(50000, 20000));
         measure(c - 1, -1, 0);
         measure(c - 1, ep[c-1], eo[c-1]);
      end
      $display("test channels done");
      bad = '{0, 5000, 50000, 5, 5000, 50000, 1, 10001, 50000,
         1, 5000, 0, 1, 5000, 50001};
      for (int k = 0; k < 15; k += 3) begin
         send(bad[k], bad[k+1], bad[k+2]);
         chk_lvl({3'h0, set_error}, 4'h1, "refused");
      end
      measure(0, ep[0], eo[0]);
      op = ep[0];
      oo = eo[0];
      send(1, 9500, 40000);
      chk_lvl({3'h0, set_error}, 4'h0, "error kept");
      measure(0, op, oo);
      send(4, $urandom_range(9900, 100), 10000);
      measure(3, -1, 0);
      $display("test refuse and update done");
      send(2, 0, 50000);
      send(3, 10000, 50000);
      // Servo pulse of 1.5 ms: on for 75000 clocks from its start
      send(4, 750, 50);
      repeat (6000) @(posedge clk);
      for (int k = 0; k < 8; k++) begin
         repeat ($urandom_range(300, 1)) tick();
         chk_lvl(pwm_out & 4'h6, 4'h4, "limits");
         chk_lvl({3'h0, pwm_out[3]}, 4'h1, "servo pulse");
      end
      $display("test limits done");
      final_report();
   end
endmodule
`default_nettype wire
